// ### src/tohp_pkg.sv
// Constants shared by the overhead insert port logic
package tohp_pkg;
   // --------------------------------------------------------------
   // Frame geometry of the insertable overhead
   // --------------------------------------------------------------
   localparam int unsigned BYTE_BITS = 8;
   localparam int unsigned TOH_BYTES = 27;
   localparam int unsigned TOH_BITS  = TOH_BYTES * BYTE_BITS;
   localparam int unsigned IDX_W     = 5;
   localparam int unsigned BITCNT_W  = 8;
   localparam int unsigned STS_W     = 2;

   // --------------------------------------------------------------
   // Typed forms of the constants at the widths they meet
   // --------------------------------------------------------------
   localparam logic [STS_W-1:0]    FIRST_STS   = 2'h0;
   localparam logic [IDX_W-1:0]    IDX_LAST    = 5'(TOH_BYTES - 1);
   localparam logic [IDX_W-1:0]    IDX_END     = 5'(TOH_BYTES);
   localparam logic [BITCNT_W-1:0] BIT_LAST    = 8'(TOH_BITS - 1);
   localparam logic [2:0]          BIT_IN_LAST = 3'h7;
   localparam logic [7:0]          BYTE_RESET  = 8'h00;
endpackage

// ### src/tohp_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module tohp_sync (
   // Clock, reset and enable of the receiving domain
   input  wire logic clk,
   input  wire logic rstN,
   input  wire logic en,
   // Level from the other domain and its safe copy
   input  wire logic d,
   output logic      q
);
   logic stage1Reg;

   // First stage is read by the second stage only
   always_ff @(posedge clk) begin
      if (!rstN) begin
         stage1Reg <= 1'b0;
         q         <= 1'b0;
      end else if (en) begin
         stage1Reg <= d;
         q         <= stage1Reg;
      end
   end
endmodule

// ### src/tohp_insert_port.sv
// Serial overhead insert port for the first STS-1 of the outbound stream
`timescale 1ns/100ps
import tohp_pkg::*;

module tohp_insert_port (
   // Core clock, reset and enable
   input  wire logic                        core_clk,
   input  wire logic                        nrst,
   input  wire logic                        ce,
   // Outbound byte stream from the transmit path
   input  wire logic [7:0]                  txByteIn,
   input  wire logic                        txValid,
   input  wire logic                        txTohByte,
   input  wire logic [tohp_pkg::STS_W-1:0] txStsIdx,
   input  wire logic                        txFrameStart,
   // Outbound byte stream after insertion
   output logic [7:0]                       txByteOut,
   output logic                             txValidOut,
   // Link side
   input  wire logic                        portClk,
   output logic                             overhead_port_clock_out,
   output logic                             overhead_port_ready,
   output logic                             overhead_frame_marker,
   input  wire logic                        overhead_insert_request,
   input  wire logic                        overhead_serial_data_in
);
   import tohp_pkg::*;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic                frameTogReg;
   logic                frameTogSync;
   logic                frameSeenReg;
   logic                linkRstN;
   logic                linkCe;
   logic                markerReg;
   logic                readyReg;
   logic [BITCNT_W-1:0] bitCntReg;
   logic [7:0]          shReg;
   logic [7:0]          mskReg;
   logic [7:0]          sendDataReg;
   logic [7:0]          sendMaskReg;
   logic [IDX_W-1:0]    sendIdxReg;
   logic                reqTogReg;
   logic                reqTogSync;
   logic                reqSeenReg;
   logic [IDX_W-1:0]    tohIdxReg;
   // Store of port bytes and their bit masks, one entry per index
   logic [7:0]          tohData [TOH_BYTES];
   logic [7:0]          tohMask [TOH_BYTES];

   // ----------------------------------------------------------------
   // Port clock and crossings
   // ----------------------------------------------------------------
   // The link clock is forwarded as is, so it runs free
   assign overhead_port_clock_out = portClk;

   tohp_sync uRstSync (
      .clk  (portClk),
      .rstN (1'b1),
      .en   (1'b1),
      .d    (nrst),
      .q    (linkRstN)
   );

   tohp_sync uCeSync (
      .clk  (portClk),
      .rstN (linkRstN),
      .en   (1'b1),
      .d    (ce),
      .q    (linkCe)
   );

   tohp_sync uFrameSync (
      .clk  (portClk),
      .rstN (linkRstN),
      .en   (linkCe),
      .d    (frameTogReg),
      .q    (frameTogSync)
   );

   tohp_sync uReqSync (
      .clk  (core_clk),
      .rstN (nrst),
      .en   (ce),
      .d    (reqTogReg),
      .q    (reqTogSync)
   );

   // ----------------------------------------------------------------
   // Link side: marker, ready window and serial capture
   // ----------------------------------------------------------------
   wire       frameEdge = frameTogSync ^ frameSeenReg;
   wire       capture   = readyReg & overhead_insert_request;
   // Request low leaves the data input unread and the bit unmasked
   wire       takeBit   = capture & overhead_serial_data_in;
   wire [7:0] shNext    = {shReg[6:0], takeBit};
   wire [7:0] mskNext   = {mskReg[6:0], capture};
   wire       byteDone  = readyReg && (bitCntReg[2:0] == BIT_IN_LAST);
   wire       lastBit   = readyReg && (bitCntReg == BIT_LAST);

   assign overhead_frame_marker = markerReg;
   assign overhead_port_ready   = readyReg;

   always_ff @(posedge portClk) begin
      if (!linkRstN) begin
         frameSeenReg <= 1'b0;
         markerReg    <= 1'b0;
         readyReg     <= 1'b0;
         bitCntReg    <= '0;
         shReg        <= BYTE_RESET;
         mskReg       <= BYTE_RESET;
      end else if (linkCe) begin
         frameSeenReg <= frameTogSync;
         markerReg    <= frameEdge;
         if (readyReg) begin
            bitCntReg <= 8'(bitCntReg + 8'h01);
            shReg     <= shNext;
            mskReg    <= mskNext;
         end
         // A new marker restarts the window and wins over the count,
         // so a frame that comes early still lines up its bits
         if (markerReg) begin
            readyReg  <= 1'b1;
            bitCntReg <= '0;
         end else if (lastBit) begin
            readyReg  <= 1'b0;
         end
      end
   end

   // Word stays stable for eight port clocks, far longer than the
   // synchroniser delay, so a toggle alone hands it over safely
   always_ff @(posedge portClk) begin
      if (!linkRstN) begin
         sendDataReg <= BYTE_RESET;
         sendMaskReg <= BYTE_RESET;
         sendIdxReg  <= '0;
         reqTogReg   <= 1'b0;
      end else if (linkCe && byteDone) begin
         sendDataReg <= shNext;
         sendMaskReg <= mskNext;
         sendIdxReg  <= bitCntReg[7:3];
         reqTogReg   <= ~reqTogReg;
      end
   end

   // ----------------------------------------------------------------
   // Core side: overhead store
   // ----------------------------------------------------------------
   // Each toggle of the port side's flag marks one fresh byte
   wire newWord = reqTogSync ^ reqSeenReg;

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         reqSeenReg  <= 1'b0;
         frameTogReg <= 1'b0;
      end else if (ce) begin
         reqSeenReg <= reqTogSync;
         if (txValid && txFrameStart) begin
            frameTogReg <= ~frameTogReg;
         end
      end
   end

   for (genvar i = 0; i < TOH_BYTES; i++) begin : gEntry
      wire hit = newWord && (sendIdxReg == 5'(i));
      always_ff @(posedge core_clk) begin
         if (!nrst) begin
            tohData[i] <= BYTE_RESET;
            tohMask[i] <= BYTE_RESET;
         end else if (ce && hit) begin
            tohData[i] <= sendDataReg;
            tohMask[i] <= sendMaskReg;
         end
      end
   end

   // ----------------------------------------------------------------
   // Core side: insertion into the first STS-1 only
   // ----------------------------------------------------------------
   wire [IDX_W-1:0] idxCur  = txFrameStart ? '0 : tohIdxReg;
   wire             isOurs  = txTohByte && (txStsIdx == FIRST_STS);
   wire             idxOk   = idxCur <= IDX_LAST;
   wire [IDX_W-1:0] idxSel  = idxOk ? idxCur : '0;
   wire [7:0]       selMask = (isOurs && idxOk) ? tohMask[idxSel] : 8'h00;
   // Stored values apply one frame later; unmasked bits pass through
   wire [7:0]       mixed   = (tohData[idxSel] & selMask)
                            | (txByteIn & ~selMask);

   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         tohIdxReg  <= '0;
         txByteOut  <= BYTE_RESET;
         txValidOut <= 1'b0;
      end else if (ce) begin
         txValidOut <= txValid;
         if (txValid) begin
            txByteOut <= mixed;
            if (isOurs && idxOk) begin
               tohIdxReg <= 5'(idxCur + 5'h01);
            end else if (txFrameStart) begin
               tohIdxReg <= '0;
            end
         end
      end
   end
endmodule

// ### verif/tohp_insert_port_checker.sv
// Checker for the overhead insert port
`timescale 1ns/100ps
module tohp_insert_port_checker import tohp_pkg::*; (
   // Core domain
   input wire logic                        core_clk,
   input wire logic                        nrst,
   input wire logic                        ce,
   input wire logic                        txValid,
   input wire logic                        txTohByte,
   input wire logic                        txValidOut,
   input wire logic [7:0]                  txByteIn,
   input wire logic [7:0]                  txByteOut,
   input wire logic [tohp_pkg::STS_W-1:0] txStsIdx,
   // Port domain
   input wire logic                        portClk,
   input wire logic                        overhead_port_clock_out,
   input wire logic                        overhead_port_ready,
   input wire logic                        overhead_frame_marker
);
   wire        rdy = overhead_port_ready;
   wire        mk  = overhead_frame_marker;
   logic [2:0] linkRst_reg;
   logic [8:0] rdyCnt_reg;
   wire        linkOn = nrst && linkRst_reg[2];
   // The port side leaves reset some port clocks after nrst; waiting as
   // long keeps history from before its reset out of the past values
   always_ff @(posedge portClk) begin
      if (!nrst) linkRst_reg <= 3'h0;
      else linkRst_reg <= {linkRst_reg[1:0], 1'b1};
   end
   // Counts ready cycles so the window length is checked without repetition
   always_ff @(posedge portClk) begin
      if (!linkOn || !rdy) rdyCnt_reg <= 9'h000;
      else rdyCnt_reg <= rdyCnt_reg + 9'h001;
   end
   AST_CLK_FWD: assert property (
      @(posedge core_clk) overhead_port_clock_out == portClk)
      else $error("port clock not forwarded");
   AST_MARK_ONE: assert property (
      @(posedge portClk) disable iff (!linkOn) $rose(mk) |=> !mk)
      else $error("marker longer than one period");
   AST_RDY_FOLLOW: assert property (
      @(posedge portClk) disable iff (!linkOn) mk |=> rdy)
      else $error("ready not one period after marker");
   AST_RDY_CAUSE: assert property (
      @(posedge portClk) disable iff (!linkOn) $rose(rdy) |-> $past(mk))
      else $error("ready rose without marker");
   AST_RDY_LEN: assert property (
      @(posedge portClk) disable iff (!linkOn)
      $fell(rdy) |-> rdyCnt_reg == 9'h0d8) else $error("ready length wrong");
   AST_VALID_LAT: assert property (
      @(posedge core_clk) disable iff (!nrst)
      ce |=> txValidOut == $past(txValid)) else $error("valid latency wrong");
   AST_PASS: assert property (
      @(posedge core_clk) disable iff (!nrst) ce && txValid && !txTohByte
      |=> txByteOut == $past(txByteIn)) else $error("payload byte changed");
   AST_OTHER_STS: assert property (
      @(posedge core_clk) disable iff (!nrst)
      ce && txValid && txTohByte && txStsIdx != FIRST_STS
      |=> txByteOut == $past(txByteIn)) else $error("other STS-1 changed");
endmodule
bind tohp_insert_port tohp_insert_port_checker i_tohp_insert_port_checker (
   .core_clk, .nrst, .ce, .txValid, .txTohByte, .txValidOut, .txByteIn,
   .txByteOut, .txStsIdx, .portClk, .overhead_port_clock_out,
   .overhead_port_ready, .overhead_frame_marker);

// ### verif/tohp_far_end.sv
// Far-end overhead source feeding the serial insert port
`timescale 1ns/100ps
module tohp_far_end (
   // Port clock, ready and marker from the device
   input  wire logic         portClkIn,
   input  wire logic         ready,
   input  wire logic         marker,
   // Bits to send, byte 0 MSB first at the top, and bytes to leave alone
   input  wire logic [215:0] patBits,
   input  wire logic [26:0]  skipByte,
   // Request and serial data to the device
   output logic              insReq,
   output logic              serData
);
   logic [7:0] bitCnt_reg = 8'h00;
   initial begin
      insReq = 1'b0;
      serData = 1'b0;
   end
   always @(posedge portClkIn) begin
      if (marker) bitCnt_reg <= 8'h00;
      else if (ready) bitCnt_reg <= bitCnt_reg + 8'h01;
   end
   // Launch on the falling edge so data is settled at the capture edge
   always @(negedge portClkIn) begin
      insReq <= ready && !skipByte[bitCnt_reg[7:3]];
      // An unrequested line toggles so stale data can never match
      if (ready && !skipByte[bitCnt_reg[7:3]])
         serData <= patBits[8'hd7 - bitCnt_reg];
      else serData <= ~serData;
   end
endmodule

// ### verif/tb_top.sv
// Bench for the overhead insert port with a far-end model
`timescale 1ns/100ps
module tb_top;
   logic core_clk = 1'b0, portClk = 1'b0, nrst = 1'b0, txValid = 1'b0;
   logic txTohByte = 1'b0, txFrameStart = 1'b0, txValidOut, clkOut;
   logic ready, marker, insReq, serData;
   logic [7:0] txByteIn = 8'h00, txByteOut, seed = 8'h59;
   logic [1:0] txStsIdx = 2'h0;
   logic [215:0] patBits = 216'h0;
   logic [26:0] skipByte = 27'h0;
   logic [8:0] expQ[$];
   int fail_count = 0, total_checks = 0, cycles = 0;
   always #5 core_clk = ~core_clk;
   always #40 portClk = ~portClk;
   tohp_insert_port i_tohp_insert_port (.core_clk, .nrst, .ce(1'b1),
      .txByteIn, .txValid, .txTohByte, .txStsIdx, .txFrameStart,
      .txByteOut, .txValidOut, .portClk, .overhead_port_clock_out(clkOut),
      .overhead_port_ready(ready), .overhead_frame_marker(marker),
      .overhead_insert_request(insReq), .overhead_serial_data_in(serData));
   tohp_far_end i_tohp_far_end (.portClkIn(clkOut), .ready, .marker,
      .patBits, .skipByte, .insReq, .serData);
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic check(input logic [8:0] e, input logic [7:0] g);
      total_checks++;
      if (!e[8] && g !== e[7:0]) begin
         fail_count++;
         $display("ERROR %0t byte %h expected %h", $time, g, e[7:0]);
      end
   endtask
   task automatic tally_and_finish();
      if (expQ.size() != 0) begin
         fail_count++;
         $display("ERROR %0t %0d bytes never came out", $time, expQ.size());
      end
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(negedge core_clk) begin
      if (txValidOut === 1'b1)
         check(expQ.pop_front(), txByteOut);
   end
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         $display("ERROR %0t run did not end in time", $time);
         tally_and_finish();
      end
   end
   // One outbound frame checked against what the last port frame carried
   task automatic frame(input logic chk);
      logic [8:0] e;
      logic [215:0] oldPat;
      logic [26:0] oldSkip;
      oldPat = patBits;
      oldSkip = skipByte;
      for (int k = 0; k < 27; k++) begin
         seed = lfsr(seed);
         patBits[215 - 8*k -: 8] = seed;
         skipByte[k] = (seed[2:0] == 3'h0);
      end
      for (int i = 0; i < 91; i++) begin
         seed = lfsr(seed);
         txValid = 1'b1;
         txFrameStart = (i == 0);
         txTohByte = (i < 81);
         txStsIdx = 2'(i % 3);
         txByteIn = seed;
         e = {1'b0, seed};
         // Round 0 meets the cleared store, which passes every byte
         if (chk && i < 81 && i % 3 == 0 && !oldSkip[i/3])
            e[7:0] = oldPat[215 - 8*(i/3) -: 8];
         expQ.push_back(e);
         @(posedge core_clk);
         #1;
      end
      txValid = 1'b0;
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      #1 nrst = 1'b1;
      repeat (40) @(posedge core_clk);
      #1;
      for (int r = 0; r < 4; r++) begin
         frame(r > 0);
         repeat (2000) @(posedge core_clk);
         #1;
         $display("round %0d done, checks %0d", r, total_checks);
      end
      tally_and_finish();
   end
endmodule
